// ===== design/pmc_power_mode_ctrl.sv
// Power mode controller: mode state machine, clock/power steering, AXI4-Lite registers
// Assumes wait_instr comes from logic on aclk; wake and request inputs are asynchronous
`timescale 1ns/10ps
`include "pmc_params.svh"

module pmc_power_mode_ctrl #(
  parameter int ADDR_W = 8,
  parameter int SETTLE_CYC = `PMC_SETTLE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Processor and peripheral events
  input wire logic wait_instr,
  input wire logic wake_event,
  input wire logic fast_clk_req,
  input wire logic external_reset_pin_n,
  input wire logic debug_wire_active,
  input wire logic io_level_match,
  // Power and oscillator controls
  output logic core_regulator_en,
  output logic fast_power_domain_en,
  output logic low_power_domain_en,
  output logic fast_internal_osc_en,
  output logic fast_osc_gear_4mhz,
  output logic slow_internal_osc_en,
  // Clock steering
  output logic main_clock_en,
  output logic main_clock_from_fast,
  output logic processor_clock_en,
  output logic low_power_bus_clock_en,
  output logic [1:0] low_power_bus_clock_rate,
  output logic slow_clock_en,
  output logic basic_timers_pair_clk_en,
  output logic other_lp_periph_clk_en,
  output logic fast_clk_grant
);

  pmc_pkg::pmc_state_type state;
  pmc_pkg::pmc_state_type next_state;
  logic [4:0] sync_meta;
  logic [4:0] sync_q;
  logic wake_s;
  logic req_s;
  logic shut_wake;
  logic [`PMC_CTRL_W-1:0] ctrl;
  logic [1:0] run_pol;
  logic [1:0] lp_mode;
  logic [1:0] lp_pol;
  logic [7:0] settle_cnt;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] stat_word;
  logic next_reg;
  logic next_fdom;
  logic next_ldom;
  logic next_fosc;
  logic next_gear;
  logic next_sosc;
  logic next_main;
  logic next_main_fast;
  logic next_cpu;
  logic next_lpbus;
  pmc_pkg::pmc_rate_type next_rate;
  logic next_slow;
  logic next_other;
  logic next_grant;

  // Two-flop synchronisers for all asynchronous inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_meta <= 5'h00;
      sync_q <= 5'h00;
    end else begin
      sync_meta <= {io_level_match, debug_wire_active, ~external_reset_pin_n,
                    fast_clk_req, wake_event};
      sync_q <= sync_meta;
    end
  end

  assign wake_s = sync_q[0];
  assign req_s = sync_q[1];
  assign shut_wake = |sync_q[4:2];
  assign run_pol = ctrl[`PMC_RUNPOL_LSB +: 2];
  assign lp_mode = ctrl[`PMC_LPMODE_LSB +: 2];
  assign lp_pol = ctrl[`PMC_LPPOL_LSB +: 2];

  // Mode transitions
  always_comb begin
    next_state = state;
    unique case (state)
      pmc_pkg::ST_RUN: begin
        if (wait_instr) begin
          unique case (lp_mode)
            `PMC_LP_SLEEP: next_state = pmc_pkg::ST_SLEEP;
            `PMC_LP_STOP: next_state = pmc_pkg::ST_STOP;
            `PMC_LP_STANDBY: next_state = pmc_pkg::ST_STANDBY;
            default: next_state = pmc_pkg::ST_SHUTDOWN;
          endcase
        end
      end
      pmc_pkg::ST_SLEEP, pmc_pkg::ST_STOP, pmc_pkg::ST_STANDBY: begin
        if (wake_s) begin
          next_state = pmc_pkg::ST_WAKE;
        end
      end
      pmc_pkg::ST_SHUTDOWN: begin
        if (shut_wake) begin
          next_state = pmc_pkg::ST_WAKE;
        end
      end
      pmc_pkg::ST_WAKE: begin
        if (settle_cnt >= 8'(SETTLE_CYC - 1)) begin
          next_state = pmc_pkg::ST_RUN;
        end
      end
      default: next_state = pmc_pkg::ST_RUN;
    endcase
  end

  // Mode register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= pmc_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Settle counter while domains and oscillators come back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt <= 8'h00;
    end else if (state == pmc_pkg::ST_WAKE) begin
      settle_cnt <= settle_cnt + 8'h01;
    end else begin
      settle_cnt <= 8'h00;
    end
  end

  // Power and clock settings for the mode being entered
  always_comb begin
    next_reg = 1'b1;
    next_fdom = 1'b0;
    next_ldom = 1'b1;
    next_fosc = 1'b0;
    next_gear = 1'b0;
    next_sosc = 1'b1;
    next_main = 1'b0;
    next_main_fast = 1'b0;
    next_cpu = 1'b0;
    next_lpbus = 1'b1;
    next_rate = pmc_pkg::RATE_FULL;
    next_slow = 1'b1;
    next_other = 1'b1;
    next_grant = 1'b0;
    unique case (next_state)
      pmc_pkg::ST_RUN, pmc_pkg::ST_WAKE: begin
        next_fdom = 1'b1;
        next_fosc = (run_pol < 2'h2);
        next_main = 1'b1;
        next_main_fast = (run_pol == 2'h0);
        next_cpu = (next_state == pmc_pkg::ST_RUN);
      end
      pmc_pkg::ST_SLEEP: begin
        next_fdom = 1'b1;
        next_fosc = (lp_pol < 2'h2);
        next_main = 1'b1;
        next_main_fast = (lp_pol == 2'h0);
      end
      pmc_pkg::ST_STOP: begin
        if (lp_pol == 2'h0) begin
          next_fosc = (run_pol < 2'h2);
          next_rate = pmc_pkg::RATE_CAP4M;
        end else if (lp_pol == 2'h1) begin
          next_fosc = 1'b1;
          next_gear = 1'b1;
          next_rate = pmc_pkg::RATE_CAP4M;
        end else begin
          next_rate = pmc_pkg::RATE_32K;
        end
      end
      pmc_pkg::ST_STANDBY: begin
        next_rate = pmc_pkg::RATE_32K;
        next_other = (lp_pol == 2'h0);
      end
      default: begin
        next_reg = 1'b0;
        next_ldom = 1'b0;
        next_sosc = 1'b0;
        next_lpbus = 1'b0;
        next_slow = 1'b0;
        next_other = 1'b0;
      end
    endcase
    // Fast clock request lifts the bus to full speed in stop and standby
    if (req_s && (next_state == pmc_pkg::ST_STOP || next_state == pmc_pkg::ST_STANDBY)) begin
      next_grant = 1'b1;
      next_fosc = 1'b1;
      next_gear = 1'b0;
      next_rate = pmc_pkg::RATE_FULL;
      next_other = 1'b1;
    end
  end

  // Registered power and clock outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_regulator_en <= 1'b1;
      fast_power_domain_en <= 1'b1;
      low_power_domain_en <= 1'b1;
      fast_internal_osc_en <= 1'b1;
      fast_osc_gear_4mhz <= 1'b0;
      slow_internal_osc_en <= 1'b1;
      main_clock_en <= 1'b1;
      main_clock_from_fast <= 1'b1;
      processor_clock_en <= 1'b1;
      low_power_bus_clock_en <= 1'b1;
      low_power_bus_clock_rate <= pmc_pkg::RATE_FULL;
      slow_clock_en <= 1'b1;
      basic_timers_pair_clk_en <= 1'b1;
      other_lp_periph_clk_en <= 1'b1;
      fast_clk_grant <= 1'b0;
    end else begin
      core_regulator_en <= next_reg;
      fast_power_domain_en <= next_fdom;
      low_power_domain_en <= next_ldom;
      fast_internal_osc_en <= next_fosc;
      fast_osc_gear_4mhz <= next_gear;
      slow_internal_osc_en <= next_sosc;
      main_clock_en <= next_main;
      main_clock_from_fast <= next_main_fast;
      processor_clock_en <= next_cpu;
      low_power_bus_clock_en <= next_lpbus;
      low_power_bus_clock_rate <= next_rate;
      slow_clock_en <= next_slow;
      basic_timers_pair_clk_en <= next_lpbus;
      other_lp_periph_clk_en <= next_other;
      fast_clk_grant <= next_grant;
    end
  end

  // Write channel acceptance, address and data in either order
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (aw_held && w_held) begin
      w_held <= 1'b0;
    end
  end

  // Control register write and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `PMC_CTRL_RST;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else if (aw_held && w_held) begin
      bvalid <= 1'b1;
      if (aw_addr_q[ADDR_W-1:2] == `PMC_CTRL_OFF >> 2) begin
        bresp <= 2'h0;
        if (w_strb_q[0]) begin
          ctrl <= w_data_q[`PMC_CTRL_W-1:0];
        end
      end else if (aw_addr_q[ADDR_W-1:2] == `PMC_STAT_OFF >> 2) begin
        bresp <= 2'h0;
      end else begin
        bresp <= 2'h2;
      end
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Status word shows live mode and controls
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[5:0] = state;
    stat_word[`PMC_STAT_GRANT] = fast_clk_grant;
    stat_word[`PMC_STAT_FDOM] = fast_power_domain_en;
    stat_word[`PMC_STAT_LDOM] = low_power_domain_en;
    stat_word[`PMC_STAT_FOSC] = fast_internal_osc_en;
    stat_word[`PMC_STAT_CPU] = processor_clock_en;
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= 2'h0;
      if (araddr[ADDR_W-1:2] == `PMC_CTRL_OFF >> 2) begin
        rdata <= {26'h0, ctrl};
      end else if (araddr[ADDR_W-1:2] == `PMC_STAT_OFF >> 2) begin
        rdata <= stat_word;
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= 2'h2;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Checks on mode and clock steering
  // Outputs are registered from the policy fields, so those are compared one edge late
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence lp_wake_s;
    (state inside {pmc_pkg::ST_SLEEP, pmc_pkg::ST_STOP, pmc_pkg::ST_STANDBY}) && wake_s;
  endsequence

  sequence wake_settled_s;
    (state == pmc_pkg::ST_WAKE) ##[1:64] (state == pmc_pkg::ST_RUN);
  endsequence

  only_run_exec_a: assert property (
    processor_clock_en |-> state == pmc_pkg::ST_RUN)
    else $error("processor clock outside run");

  irq_wake_a: assert property (
    lp_wake_s |=> wake_settled_s)
    else $error("wake event did not return to run");

  shutdown_off_a: assert property (
    state == pmc_pkg::ST_SHUTDOWN && !shut_wake |=> state == pmc_pkg::ST_SHUTDOWN
      && !core_regulator_en)
    else $error("shutdown left without allowed source");

  fast_domain_a: assert property (
    fast_power_domain_en == (state inside {pmc_pkg::ST_RUN, pmc_pkg::ST_SLEEP,
      pmc_pkg::ST_WAKE}))
    else $error("fast domain power wrong for mode");

  shutdown_dark_a: assert property (
    state == pmc_pkg::ST_SHUTDOWN |-> !low_power_domain_en && !main_clock_en
      && !low_power_bus_clock_en && !slow_clock_en && !slow_internal_osc_en)
    else $error("clock or power left on in shutdown");

  run_source_a: assert property (
    state == pmc_pkg::ST_RUN |-> main_clock_from_fast == ($past(run_pol) == 2'h0)
      && fast_internal_osc_en == ($past(run_pol) < 2'h2))
    else $error("run clock source wrong");

  sleep_policy_a: assert property (
    state == pmc_pkg::ST_SLEEP |-> main_clock_en && !processor_clock_en
      && main_clock_from_fast == ($past(lp_pol) == 2'h0))
    else $error("sleep clocking wrong");

  stop_retain_a: assert property (
    state == pmc_pkg::ST_STOP && $past(lp_pol) == 2'h0 && !fast_clk_grant
      |-> fast_internal_osc_en == ($past(run_pol) < 2'h2))
    else $error("stop 0 changed fast oscillator");

  stop_rate_a: assert property (
    state == pmc_pkg::ST_STOP && !fast_clk_grant |-> !fast_power_domain_en
      && low_power_bus_clock_rate == ($past(lp_pol) >= 2'h2 ? 2'h2 : 2'h1))
    else $error("stop bus rate wrong");

  standby_gate_a: assert property (
    state == pmc_pkg::ST_STANDBY && !fast_clk_grant |-> !fast_internal_osc_en
      && basic_timers_pair_clk_en && other_lp_periph_clk_en == ($past(lp_pol) == 2'h0))
    else $error("standby peripheral gating wrong");

  fast_req_a: assert property (
    (state == pmc_pkg::ST_STOP && req_s)[*2] |-> fast_clk_grant && fast_internal_osc_en)
    else $error("fast clock request not served");

  wait_entry_a: assert property (
    state == pmc_pkg::ST_RUN && wait_instr && lp_mode == `PMC_LP_STANDBY
      |=> state == pmc_pkg::ST_STANDBY)
    else $error("wait did not enter chosen mode");

  wake_order_a: assert property (
    $rose(processor_clock_en) |-> $past(state) == pmc_pkg::ST_WAKE
      && $past(fast_power_domain_en) && $past(core_regulator_en))
    else $error("processor clock before domains restored");

endmodule // pmc_power_mode_ctrl

// ===== shared/pmc_params.svh
// Register map, field positions, reset values and timing counts
// Assumes a 40 MHz aclk and 32-bit AXI4-Lite data
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
// Register byte offsets
`define PMC_CTRL_OFF 8'h00
`define PMC_STAT_OFF 8'h04
// Control fields
`define PMC_RUNPOL_LSB 0
`define PMC_LPMODE_LSB 2
`define PMC_LPPOL_LSB 4
`define PMC_CTRL_W 6
`define PMC_CTRL_RST 6'h00
// Low-power mode selector codes
`define PMC_LP_SLEEP 2'h0
`define PMC_LP_STOP 2'h1
`define PMC_LP_STANDBY 2'h2
`define PMC_LP_SHUTDOWN 2'h3
// Status fields
`define PMC_STAT_GRANT 6
`define PMC_STAT_FDOM 7
`define PMC_STAT_LDOM 8
`define PMC_STAT_FOSC 9
`define PMC_STAT_CPU 10
// Oscillator settle time before the processor clock returns
`define PMC_CLK_MHZ 40
`define PMC_SETTLE_NS 1000
`define PMC_SETTLE_CYC ((`PMC_SETTLE_NS * `PMC_CLK_MHZ + 999) / 1000)
`endif

// ===== shared/pmc_pkg.sv
// Types shared by the power mode controller
// Assumes pmc_params.svh for register and timing constants; mode and rate encodings are defined here
package pmc_pkg;
  // Operating mode, one-hot
  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_SLEEP = 6'h02,
    ST_STOP = 6'h04,
    ST_STANDBY = 6'h08,
    ST_SHUTDOWN = 6'h10,
    ST_WAKE = 6'h20
  } pmc_state_type;
  // Low-power bus clock rate
  typedef enum logic [1:0] {
    RATE_FULL = 2'h0,
    RATE_CAP4M = 2'h1,
    RATE_32K = 2'h2
  } pmc_rate_type;
endpackage

// ===== sim/pmc_power_mode_ctrl_test.sv
// Self-checking bench for the power mode controller: registers, mode table, wake, requests
// Assumes pmc_params.svh on the include path and a 40 MHz aclk; drives all ports directly
`timescale 1ns/10ps
`include "pmc_params.svh"

module pmc_power_mode_ctrl_test;
  localparam int SETTLE = 2;
  typedef struct packed {
    logic [5:0] ctrl;
    logic [1:0] src;
    logic [14:0] exp_lp;
    logic [14:0] mask;
  } pmc_row_type;
  // Clock, reset and register bus
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  // Mode events
  logic wait_instr = 1'h0, wake_event = 1'h0, fast_clk_req = 1'h0;
  logic external_reset_pin_n = 1'h1, debug_wire_active = 1'h0, io_level_match = 1'h0;
  // Power and clock outputs
  logic core_regulator_en, fast_power_domain_en, low_power_domain_en, fast_internal_osc_en;
  logic fast_osc_gear_4mhz, slow_internal_osc_en, main_clock_en, main_clock_from_fast;
  logic processor_clock_en, low_power_bus_clock_en, slow_clock_en, basic_timers_pair_clk_en;
  logic other_lp_periph_clk_en, fast_clk_grant;
  logic [1:0] low_power_bus_clock_rate;
  logic [14:0] outs;
  logic [14:0] run_exp [3];
  pmc_row_type rows [14];
  int n_fail = 0;
  int samples_checked = 0;

  pmc_power_mode_ctrl #(.SETTLE_CYC(SETTLE)) u_pmc_power_mode_ctrl (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .wait_instr, .wake_event, .fast_clk_req, .external_reset_pin_n,
    .debug_wire_active, .io_level_match, .core_regulator_en, .fast_power_domain_en,
    .low_power_domain_en, .fast_internal_osc_en, .fast_osc_gear_4mhz, .slow_internal_osc_en,
    .main_clock_en, .main_clock_from_fast, .processor_clock_en, .low_power_bus_clock_en,
    .low_power_bus_clock_rate, .slow_clock_en, .basic_timers_pair_clk_en,
    .other_lp_periph_clk_en, .fast_clk_grant);

  // Output bundle, regulator first, peripheral gates last
  assign outs = {core_regulator_en, fast_power_domain_en, low_power_domain_en,
    fast_internal_osc_en, fast_osc_gear_4mhz, slow_internal_osc_en, main_clock_en,
    main_clock_from_fast, processor_clock_en, low_power_bus_clock_en,
    low_power_bus_clock_rate, slow_clock_en, basic_timers_pair_clk_en, other_lp_periph_clk_en};

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge aclk);
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    r = bresp;
    bready <= 1'h0;
    if (bvalid !== 1'h1) n_fail++;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (rvalid !== 1'h1) n_fail++;
  endtask

  task automatic pulse_wait();
    @(posedge aclk);
    wait_instr <= 1'h1;
    @(posedge aclk);
    wait_instr <= 1'h0;
  endtask

  // Raise one wake source, count settle cycles with power back but processor halted
  task automatic wake_up(input logic [1:0] src);
    int k;
    int cnt;
    k = 0;
    cnt = 0;
    @(posedge aclk);
    case (src)
      2'h0: wake_event <= 1'h1;
      2'h1: external_reset_pin_n <= 1'h0;
      2'h2: debug_wire_active <= 1'h1;
      default: io_level_match <= 1'h1;
    endcase
    while (processor_clock_en !== 1'h1 && k < 60) begin
      @(negedge aclk);
      k++;
      if (fast_power_domain_en === 1'h1 && processor_clock_en === 1'h0) cnt++;
    end
    check("wake", processor_clock_en, 1'h1);
    check("settle", cnt >= SETTLE, 1'h1);
    @(posedge aclk);
    wake_event <= 1'h0;
    external_reset_pin_n <= 1'h1;
    debug_wire_active <= 1'h0;
    io_level_match <= 1'h0;
    tick(2);
  endtask

  // Watchdog, about 40000 cycles
  initial begin
    #1000000;
    n_fail++;
    close_out();
  end

  // Main sequence
  initial begin
    run_exp = '{15'h7be7, 15'h7b67, 15'h7367};
    rows = '{'{6'h00, 2'h0, 15'h7ba7, 15'h7fe7}, '{6'h10, 2'h0, 15'h7b27, 15'h7fe7},
      '{6'h20, 2'h0, 15'h7327, 15'h7fe7}, '{6'h04, 2'h0, 15'h5a2f, 15'h7f7f},
      '{6'h05, 2'h0, 15'h5a2f, 15'h7f7f}, '{6'h06, 2'h0, 15'h522f, 15'h7f7f},
      '{6'h14, 2'h0, 15'h5e2f, 15'h7f7f}, '{6'h24, 2'h0, 15'h5237, 15'h7f7f},
      '{6'h34, 2'h0, 15'h5237, 15'h7f7f}, '{6'h08, 2'h0, 15'h5237, 15'h7f7f},
      '{6'h18, 2'h0, 15'h5236, 15'h7f7f}, '{6'h0c, 2'h1, 15'h0000, 15'h7f67},
      '{6'h0c, 2'h2, 15'h0000, 15'h7f67}, '{6'h0c, 2'h3, 15'h0000, 15'h7f67}};
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    tick(1);
    // Reset values and register map
    check("reset outs", outs, 15'h7be7);
    check("reset grant", fast_clk_grant, 1'h0);
    axi_rd(`PMC_CTRL_OFF, rd, resp);
    check("ctrl reset", rd, 32'h00000000);
    axi_rd(`PMC_STAT_OFF, rd, resp);
    check("status reset", rd, 32'h00000781);
    axi_wr(`PMC_CTRL_OFF, 32'h0000003f, 4'h0, resp);
    axi_wr(`PMC_STAT_OFF, 32'hffffffff, 4'hf, resp);
    check("status write resp", resp, 2'h0);
    axi_rd(`PMC_CTRL_OFF, rd, resp);
    check("ctrl no strobe", rd, 32'h00000000);
    axi_rd(`PMC_STAT_OFF, rd, resp);
    check("status read only", rd, 32'h00000781);
    axi_wr(8'h08, 32'h00000001, 4'hf, resp);
    check("unmapped wr", resp, 2'h2);
    axi_rd(8'h08, rd, resp);
    check("unmapped rd", rd, 32'h00000000);
    check("unmapped rresp", resp, 2'h2);
    axi_wr(`PMC_CTRL_OFF, 32'hffffffea, 4'hf, resp);
    axi_rd(`PMC_CTRL_OFF, rd, resp);
    check("ctrl readback", rd, 32'h0000002a);
    $display("test registers done");
    // Every mode and policy entered by a wait and left by a wake
    foreach (rows[i]) begin
      axi_wr(`PMC_CTRL_OFF, {26'h0000000, rows[i].ctrl}, 4'h1, resp);
      tick(3);
      check("run policy", outs, run_exp[rows[i].ctrl[1:0]]);
      pulse_wait();
      tick(4);
      check("low power", outs & rows[i].mask, rows[i].exp_lp);
      // A peripheral wake event must not leave shutdown
      if (rows[i].src != 2'h0) begin
        @(posedge aclk);
        wake_event <= 1'h1;
        tick(4);
        check("shutdown holds", outs & rows[i].mask, 15'h0000);
      end
      wake_up(rows[i].src);
      check("resumed", outs, run_exp[rows[i].ctrl[1:0]]);
    end
    $display("test mode table done");
    // Fast request in stop 2; shutdown sources and a second wait have no effect
    axi_wr(`PMC_CTRL_OFF, 32'h00000024, 4'h1, resp);
    @(posedge aclk);
    fast_clk_req <= 1'h1;
    tick(4);
    check("grant in run", fast_clk_grant, 1'h0);
    pulse_wait();
    tick(4);
    check("request served", {fast_internal_osc_en, fast_osc_gear_4mhz,
      low_power_bus_clock_rate, other_lp_periph_clk_en, fast_clk_grant}, 6'h23);
    axi_rd(`PMC_STAT_OFF, rd, resp);
    check("status stop", rd, 32'h00000344);
    @(posedge aclk);
    io_level_match <= 1'h1;
    debug_wire_active <= 1'h1;
    tick(4);
    check("no io wake", {core_regulator_en, fast_power_domain_en}, 2'h2);
    @(posedge aclk);
    io_level_match <= 1'h0;
    debug_wire_active <= 1'h0;
    fast_clk_req <= 1'h0;
    pulse_wait();
    tick(4);
    check("request gone", outs & 15'h7f7f, 15'h5237);
    wake_up(2'h0);
    @(posedge aclk);
    wake_event <= 1'h1;
    tick(4);
    check("wake in run", outs, 15'h7be7);
    @(posedge aclk);
    wake_event <= 1'h0;
    $display("test fast request done");
    // Second reset while asleep
    axi_wr(`PMC_CTRL_OFF, 32'h00000010, 4'h1, resp);
    pulse_wait();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    tick(1);
    check("reset outs", outs, 15'h7be7);
    axi_rd(`PMC_CTRL_OFF, rd, resp);
    check("ctrl reset", rd, 32'h00000000);
    $display("test reset done");
    close_out();
  end
endmodule // pmc_power_mode_ctrl_test
